// ### src/pps_regs.svh
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH

// Register byte offsets
`define PPS_OFS_FAULT       32'h0000_0000
`define PPS_OFS_CCP_CLK     32'h0000_0004
`define PPS_OFS_UART_ONE    32'h0000_0008
`define PPS_OFS_UART_TWO    32'h0000_000c
`define PPS_OFS_SPI_ONE     32'h0000_0010
`define PPS_OFS_SPI_ONE_SS  32'h0000_0014
`define PPS_OFS_SPI_TWO     32'h0000_0018
`define PPS_OFS_TMR_SS_TWO  32'h0000_001c
`define PPS_OFS_LOGIC_IN    32'h0000_0020

// Register map size
`define PPS_NUM_REGS        9
`define PPS_NUM_FIELDS      18
`define PPS_IDX_LSB         2
`define PPS_IDX_W           4

// Field layout
`define PPS_FIELD_W         6
`define PPS_LO_LSB          0
`define PPS_HI_LSB          8
`define PPS_LANE_W          8
`define PPS_SS_ONE_HI_FIELD 11

// Reset values
`define PPS_FIELD_RST       6'h3f
`define PPS_PIN_RST         64'h0000_0000_0000_0000

// Pins
`define PPS_NUM_PINS        64

// Bus answers
`define PPS_RESP_OKAY       2'h0
`define PPS_RESP_SLVERR     2'h2

`endif

// ### src/pps_pkg.sv
package pps_pkg;

    typedef logic [5:0]  pps_field_t;
    typedef logic [63:0] pps_pins_t;

    // Pending write held between address and data arrival
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] data;
        logic [1:0]  strb;
    } pps_wr_s;

    // Routed inputs toward the on-chip peripherals
    typedef struct packed {
        logic fault_a;
        logic fault_b;
        logic ccp_clk_a;
        logic ccp_clk_b;
        logic uart_one_rx;
        logic uart_one_cts;
        logic uart_two_rx;
        logic uart_two_cts;
        logic spi_one_data;
        logic spi_one_clock;
        logic spi_one_select;
        logic spi_two_data;
        logic spi_two_clock;
        logic spi_two_select;
        logic gp_timer_clock;
        logic logic_in_a;
        logic logic_in_b;
    } pps_periph_s;

endpackage : pps_pkg

// ### src/pps_top.sv
// How it works
// - Fault register high field routes fault B, low field fault A
// - Timer clock register high field routes clock B, low field clock A
// - First UART register: high field clear-to-send, low field receive
// - Second UART register: high field clear-to-send, low field receive
// - First SPI register: high field clock input, low field data input
// - First SPI select register uses only low field; upper bits absent
// - Second SPI register: high field clock input, low field data input
// - High field routes timer external clock, low field second SPI select
// - Logic input register: high field input B, low field input A
// - Bits 15-14 and 7-6 read zero and ignore writes
// - Implemented field bits reset to one and stay read-write
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pps_regs.svh"

module pps_top
    import pps_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Remappable device pins
    input  wire pps_pins_t   remappable_io_pin,
    // Routed peripheral inputs
    output pps_periph_s      periph_in
);

////////////////////////////////////////////////////////////////////////////////
// Decoding helpers

    function automatic logic field_impl(input int unsigned idx);
        return idx != `PPS_SS_ONE_HI_FIELD;
    endfunction : field_impl

    function automatic logic addr_hit(input logic [31:0] a);
        return (a[1:0] == 2'h0) &&
               (a[31:2] < 30'(`PPS_NUM_REGS));
    endfunction : addr_hit

    function automatic logic [3:0] addr_idx(input logic [31:0] a);
        return a[`PPS_IDX_LSB +: `PPS_IDX_W];
    endfunction : addr_idx

    function automatic logic field_hit(input logic [31:0] a,
                                       input logic [1:0]  strb,
                                       input int unsigned idx);
        return (addr_idx(a) == 4'(idx / 2)) && field_impl(idx) &&
               strb[idx % 2];
    endfunction : field_hit

    function automatic logic [31:0] pack_word(input pps_field_t hi,
                                              input pps_field_t lo);
        logic [31:0] w;
        w                              = 32'h0000_0000;
        w[`PPS_HI_LSB +: `PPS_FIELD_W] = hi;
        w[`PPS_LO_LSB +: `PPS_FIELD_W] = lo;
        return w;
    endfunction : pack_word

////////////////////////////////////////////////////////////////////////////////
// State

    logic                   aw_held_r;
    logic                   aw_held_nxt;
    logic                   w_held_r;
    logic                   w_held_nxt;
    pps_wr_s                wr_r;
    pps_wr_s                wr_nxt;
    logic                   bvalid_r;
    logic                   bvalid_nxt;
    logic [1:0]             bresp_r;
    logic [1:0]             bresp_nxt;
    logic                   rvalid_r;
    logic                   rvalid_nxt;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;
    logic [1:0]             rresp_r;
    logic [1:0]             rresp_nxt;

    pps_field_t             field_r   [`PPS_NUM_FIELDS];
    pps_field_t             field_nxt [`PPS_NUM_FIELDS];

    pps_pins_t              sync1_r;
    pps_pins_t              sync2_r;
    logic [17:0]            periph_r;
    logic [17:0]            periph_nxt;

    logic                   do_wr;
    logic                   wr_ok;
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;

////////////////////////////////////////////////////////////////////////////////
// Bus handshakes

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign do_wr   = aw_held_r && w_held_r;
    assign wr_ok   = addr_hit(wr_r.addr);

////////////////////////////////////////////////////////////////////////////////
// Write path

    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        wr_nxt      = wr_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (aw_take) begin
            aw_held_nxt = 1'b1;
            wr_nxt.addr = s_axi_awaddr;
        end
        if (w_take) begin
            w_held_nxt  = 1'b1;
            wr_nxt.data = s_axi_wdata[15:0];
            wr_nxt.strb = s_axi_wstrb[1:0];
        end
        if (do_wr) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_ok ? `PPS_RESP_OKAY
                                : `PPS_RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            wr_r      <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `PPS_RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            wr_r      <= wr_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Select fields

    always_comb begin
        for (int i = 0; i < `PPS_NUM_FIELDS; i++) begin
            field_nxt[i] = field_r[i];
            if (do_wr && wr_ok &&
                field_hit(wr_r.addr, wr_r.strb, i)) begin
                // Bits 7-6 and 15-14 never reach a field
                field_nxt[i] = wr_r.data[(i % 2) * `PPS_LANE_W +:
                                         `PPS_FIELD_W];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `PPS_NUM_FIELDS; i++) begin
                field_r[i] <= `PPS_FIELD_RST;
            end
        end else begin
            for (int i = 0; i < `PPS_NUM_FIELDS; i++) begin
                field_r[i] <= field_nxt[i];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Read path

    always_comb begin
        logic [3:0] idx;
        logic [5:0] lo;
        logic [5:0] hi;
        idx        = addr_idx(s_axi_araddr);
        lo         = '0;
        hi         = '0;
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (ar_take) begin
            rvalid_nxt = 1'b1;
            if (addr_hit(s_axi_araddr)) begin
                lo = field_r[{idx, 1'b0}];
                if (field_impl({idx, 1'b1})) begin
                    hi = field_r[{idx, 1'b1}];
                end
                rdata_nxt = pack_word(hi, lo);
                rresp_nxt = `PPS_RESP_OKAY;
            end else begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = `PPS_RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `PPS_RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= `PPS_PIN_RST;
            sync2_r <= `PPS_PIN_RST;
        end else begin
            sync1_r <= remappable_io_pin;
            sync2_r <= sync1_r;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Input routing

    for (genvar g = 0; g < `PPS_NUM_FIELDS; g++) begin : g_route
        if (field_impl(g)) begin : g_on
            assign periph_nxt[g] = sync2_r[field_r[g]];
        end else begin : g_off
            assign periph_nxt[g] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_r <= 18'h0_0000;
        end else begin
            periph_r <= periph_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Peripheral connections

    assign periph_in.fault_a        = periph_r[0];
    assign periph_in.fault_b        = periph_r[1];
    assign periph_in.ccp_clk_a      = periph_r[2];
    assign periph_in.ccp_clk_b      = periph_r[3];
    assign periph_in.uart_one_rx    = periph_r[4];
    assign periph_in.uart_one_cts   = periph_r[5];
    assign periph_in.uart_two_rx    = periph_r[6];
    assign periph_in.uart_two_cts   = periph_r[7];
    assign periph_in.spi_one_data   = periph_r[8];
    assign periph_in.spi_one_clock  = periph_r[9];
    assign periph_in.spi_one_select = periph_r[10];
    assign periph_in.spi_two_data   = periph_r[12];
    assign periph_in.spi_two_clock  = periph_r[13];
    assign periph_in.spi_two_select = periph_r[14];
    assign periph_in.gp_timer_clock = periph_r[15];
    assign periph_in.logic_in_a     = periph_r[16];
    assign periph_in.logic_in_b     = periph_r[17];

endmodule : pps_top

// ### verif/pps_top_properties.sv
`timescale 1ns/1ps
module pps_props
    import pps_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Pins and routed inputs
    input wire pps_pins_t   remappable_io_pin,
    input wire pps_periph_s periph_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    rd_gaps_a: assert property (s_axi_rvalid |->
        s_axi_rdata[31:14] == 18'h0_0000 && s_axi_rdata[7:6] == 2'h0)
        else $error("unimplemented bits not zero");
    bad_rd_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 32'h0000_0020 |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read answered");
    pins_high_a: assert property ((remappable_io_pin == '1) [*4] |->
        periph_in == 17'h1_ffff) else $error("routing not high");
    pins_low_a: assert property ((remappable_io_pin == '0) [*4] |->
        periph_in == 17'h0_0000) else $error("routing not low");
endmodule : pps_props
////////////////////////////////////////////////////////////////////////////
bind pps_top pps_props i_pps_props (.clk, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .remappable_io_pin,
    .periph_in);

// ### verif/pps_pin_model.sv
`timescale 1ns/1ps
module pps_pin_model
    import pps_pkg::*;
(
    // Clock and control
    input wire logic      clk,
    input wire logic      load,
    input wire pps_pins_t load_val,
    // Pin levels
    output pps_pins_t     pins
);
    pps_pins_t pin_r = 64'h0000_0000_0000_0000;
    always @(posedge clk) if (load) pin_r <= load_val;
    assign pins = pin_r;
endmodule : pps_pin_model

// ### verif/pps_top_test.sv
`timescale 1ns/1ps
module pps_top_test
    import pps_pkg::*;
;
    logic        clk, rst_n, awv, awrdy, wv, wrdy, bv, brdy, arv, ardy;
    logic        rv, rrdy, ld;
    logic [31:0] awa, wd, ara, rd, a;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp;
    pps_pins_t   lv, pins;
    pps_periph_s per;
    logic [16:0] pe;
    logic [15:0] mdl [9];
    integer      seed = 32'h7c50_0b5b;
    int          err_total, num_checks;
    pps_top i_pps_top (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(awv),
        .s_axi_awready(awrdy), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(ardy),
        .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
        .s_axi_rready(rrdy), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .remappable_io_pin(pins), .periph_in(per));
    pps_pin_model i_pps_pin_model (.clk(clk), .load(ld), .load_val(lv),
        .pins(pins));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [31:0] ad, d, input logic [3:0] s);
        logic ok;
        ok = ad[1:0] == 2'h0 && ad < 32'h0000_0024;
        @(posedge clk);
        awv  <= 1'b1;
        awa  <= ad;
        wv   <= 1'b1;
        wd   <= d;
        ws   <= s;
        brdy <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awrdy) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end while (!bv);
        brdy <= 1'b0;
        chk("bresp", bresp, ok ? 2'h0 : 2'h2);
        if (ok && s[0]) mdl[ad[5:2]][5:0] = d[5:0];
        if (ok && s[1] && ad != 32'h0000_0014) mdl[ad[5:2]][13:8] = d[13:8];
    endtask : wr
    task automatic rdchk(input logic [31:0] ad);
        logic ok;
        ok = ad[1:0] == 2'h0 && ad < 32'h0000_0024;
        @(posedge clk);
        arv  <= 1'b1;
        ara  <= ad;
        rrdy <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && ardy) arv <= 1'b0;
        end while (!rv);
        rrdy <= 1'b0;
        chk("rresp", rresp, ok ? 2'h0 : 2'h2);
        chk("rdata", rd, ok ? {16'h0000, mdl[ad[5:2]]} : 32'h0);
    endtask : rdchk
    function automatic logic [16:0] ep(input pps_pins_t p);
        logic [16:0] e;
        int          j;
        for (int k = 0; k < 17; k++) begin
            j = (k < 11) ? k : k + 1;
            e[16-k] = j % 2 ? p[mdl[j/2][13:8]] : p[mdl[j/2][5:0]];
        end
        return e;
    endfunction : ep
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, awv, wv, brdy, arv, rrdy, ld} = 7'h00;
        {awa, wd, ara, ws, lv} = '0;
        for (int i = 0; i < 9; i++) mdl[i] = (i == 5) ? 16'h003f : 16'h3f3f;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rdchk(32'(i * 4));
        wr(32'h0000_0002, 32'h0000_0000, 4'hf);
        rdchk(32'h0000_0002);
        wr(32'h0000_0014, 32'h0000_0000, 4'hf);
        rdchk(32'h0000_0014);
        repeat (60) begin
            a = 32'((($random(seed) & 32'h7fff_ffff) % 10) * 4);
            wr(a, $random(seed), 4'($random(seed)));
            rdchk(a);
        end
        for (int n = 0; n < 24; n++) begin
            for (int i = 0; i < 9; i++) wr(32'(i * 4), $random(seed), 4'h3);
            @(posedge clk);
            ld <= 1'b1;
            lv <= (n % 3 == 0) ? '1 : (n % 3 == 1) ? '0
                : {$random(seed), $random(seed)};
            @(posedge clk);
            ld <= 1'b0;
            repeat (5) @(posedge clk);
            pe = ep(pins);
            chk("route_upper", per[16:8], pe[16:8]);
            chk("route_lower", per[7:0], pe[7:0]);
        end
        // Mid-run reset brings every field back to pin 63
        @(posedge clk);
        ld    <= 1'b1;
        lv    <= 64'h8000_0000_0000_0000;
        rst_n <= 1'b0;
        @(posedge clk);
        ld    <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) mdl[i] = (i == 5) ? 16'h003f : 16'h3f3f;
        repeat (5) @(posedge clk);
        pe = ep(pins);
        chk("reset_route", per, pe);
        for (int i = 0; i < 9; i++) rdchk(32'(i * 4));
        give_verdict();
    end
endmodule : pps_top_test
